/* verilog/param_handshake_params.svh */
`ifndef PARAM_HANDSHAKE_PARAMS_SVH
`define PARAM_HANDSHAKE_PARAMS_SVH
// Word layout
`define CMD_BIT_POS 31
`define INVALID_BIT_POS 31
`define PARAM_BIT_POS 30
`define PNUM_LSB 25
`define PNUM_MSB 28
`define DATA_MSB 24
// Parameter numbers
`define PNUM_NONE 4'h0
`define PNUM_RESOLUTION 4'h1
`define PNUM_DIODE_OFF 4'h2
`define PNUM_AUTO_OFF 4'h5
`define PNUM_EXT_INPUT 4'hc
// Malfunction codes
`define FAULT_NONE 4'h0
`define FAULT_BAD_PARAM 4'h1
// Value limits and defaults
`define RES_MAX 25'h0000005
`define RES_DEFAULT 3'h1
`define AUTO_OFF_MAX 25'h0000001
`define EXT_IN_MAX 25'h0000003
`define EXT_IN_DIODE_OFF 2'h2
// Processing latency of one parameter, in cycles
`define PROC_CYCLES 4'h4
`endif

/* verilog/param_handshake_pkg.sv */
package param_handshake_pkg;
  typedef struct packed {
    logic enable_op;
    logic [1:0] spare;
    logic [3:0] pnum;
    logic [24:0] value;
  } cmd_word_type;

  typedef struct packed {
    logic invalid;
    logic param_mode;
    logic spare;
    logic [3:0] pnum;
    logic [24:0] value;
  } stat_word_type;

  typedef enum logic [1:0] {ST_OPERATE, ST_BUSY, ST_ECHO, ST_FAULT} hs_state_type;
endpackage

/* verilog/parameter_handshake_engine.sv */
`include "param_handshake_params.svh"

// Summary of operation
// - Operation state: state bits zero, number zero, actual position in data.
// - On accepting a parameter, both state bits set, content undefined.
// - After processing, echo number and value, stay in parameterization.
// - Valid parameters at enable: apply, clear state bits, output actual value.
// - Values are echoed unchecked; checked only at enable operation.
// - Invalid parameter at enable: malfunction, bit 31 set, code 1.
// - On range error no pending parameter is programmed.
// - Malfunction still outputs position value in data bits.
// - Parameter values are 25-bit two's complement.
// - Number 1 selects resolution, range 0 to 5, default 1.
// - Number 2 switches the emitter diode off.
// - Diode off ignored if external input is 2 or auto-off enabled.
// - Bit 31 invalid value, bit 30 parameterization state encoding.
// - Nonzero parameter number enters parameterization.
// - Malfunction code 1 means invalid parameters, 0 none.
module parameter_handshake_engine
  import param_handshake_pkg::*;
#(
  parameter int PROC_LEN = `PROC_CYCLES
) (
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire cmd_word_type host_command_word_i,
  input wire logic [24:0] position_i,
  output stat_word_type device_state_word_o,
  output logic [2:0] resolution_o,
  output logic diode_off_o
);

  hs_state_type state_reg;
  logic [3:0] cnt_reg;
  logic [3:0] last_pnum_reg;
  logic [24:0] last_value_reg;
  // Pending (unapplied) parameter set
  logic res_pend_reg, off_pend_reg, auto_pend_reg, ext_pend_reg;
  logic [24:0] res_val_reg, auto_val_reg, ext_val_reg;
  logic pend_bad_reg;
  // Applied configuration
  logic auto_off_reg;
  logic [1:0] ext_in_reg;
  logic range_err;
  logic diode_blocked;
  logic enable_seen_reg;

  // two's complement, sign bit set is out of range
  function automatic logic out_of_range(input logic [24:0] v, input logic [24:0] mx);
    out_of_range = v[24] || (v > mx);
  endfunction

  always_comb begin
    range_err = pend_bad_reg;
    if (res_pend_reg && out_of_range(res_val_reg, `RES_MAX)) range_err = 1'b1;
    if (auto_pend_reg && out_of_range(auto_val_reg, `AUTO_OFF_MAX)) range_err = 1'b1;
    if (ext_pend_reg && out_of_range(ext_val_reg, `EXT_IN_MAX)) range_err = 1'b1;
  end

  // switch-off blocking, from applied configuration or any pending auto-off/external input value that blocks
  always_comb begin
    diode_blocked = auto_off_reg || (ext_in_reg == `EXT_IN_DIODE_OFF);
    if (auto_pend_reg && auto_val_reg[0]) diode_blocked = 1'b1;
    if (ext_pend_reg && ext_val_reg[1:0] == `EXT_IN_DIODE_OFF) diode_blocked = 1'b1;
  end

  // Handshake state machine
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_reg <= ST_OPERATE;
      cnt_reg <= 4'h0;
      last_pnum_reg <= 4'h0;
      last_value_reg <= 25'h0;
    end else begin
      case (state_reg)
        ST_OPERATE, ST_FAULT: begin
          if (!host_command_word_i.enable_op && host_command_word_i.pnum != `PNUM_NONE) begin
            state_reg <= ST_BUSY;
            cnt_reg <= 4'h0;
            last_pnum_reg <= host_command_word_i.pnum;
            last_value_reg <= host_command_word_i.value;
          end else if (state_reg == ST_FAULT && host_command_word_i.enable_op &&
                       !enable_seen_reg && !range_err) begin
            state_reg <= ST_OPERATE;
          end
        end
        ST_BUSY: begin
          cnt_reg <= cnt_reg + 4'h1;
          if (cnt_reg == 4'(PROC_LEN - 1)) begin
            state_reg <= ST_ECHO;
          end
        end
        ST_ECHO: begin
          if (host_command_word_i.enable_op) begin
            state_reg <= range_err ? ST_FAULT : ST_OPERATE;
          end else if (host_command_word_i.pnum != `PNUM_NONE &&
                       host_command_word_i.pnum != last_pnum_reg) begin
            state_reg <= ST_BUSY;
            cnt_reg <= 4'h0;
            last_pnum_reg <= host_command_word_i.pnum;
            last_value_reg <= host_command_word_i.value;
          end
        end
        default: state_reg <= ST_OPERATE;
      endcase
    end
  end

  // Enable level at the last edge; the held enable that caused a fault must not clear it
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      enable_seen_reg <= 1'b0;
    end else begin
      enable_seen_reg <= host_command_word_i.enable_op;
    end
  end

  logic accept_now, enable_now;
  assign accept_now = (state_reg == ST_BUSY) && (cnt_reg == 4'(PROC_LEN - 1));
  assign enable_now = (state_reg == ST_ECHO) && host_command_word_i.enable_op;

  // Pending parameter collection and apply
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      res_pend_reg <= 1'b0;
      off_pend_reg <= 1'b0;
      auto_pend_reg <= 1'b0;
      ext_pend_reg <= 1'b0;
      pend_bad_reg <= 1'b0;
      res_val_reg <= 25'h0;
      auto_val_reg <= 25'h0;
      ext_val_reg <= 25'h0;
      resolution_o <= `RES_DEFAULT;
      auto_off_reg <= 1'b0;
      ext_in_reg <= 2'h0;
      diode_off_o <= 1'b0;
    end else if (accept_now) begin
      case (last_pnum_reg)
        `PNUM_RESOLUTION: begin
          res_pend_reg <= 1'b1;
          res_val_reg <= last_value_reg;
        end
        `PNUM_DIODE_OFF: off_pend_reg <= 1'b1;
        `PNUM_AUTO_OFF: begin
          auto_pend_reg <= 1'b1;
          auto_val_reg <= last_value_reg;
        end
        `PNUM_EXT_INPUT: begin
          ext_pend_reg <= 1'b1;
          ext_val_reg <= last_value_reg;
        end
        default: pend_bad_reg <= pend_bad_reg;
      endcase
    end else if (enable_now) begin
      if (!range_err) begin
        if (res_pend_reg) resolution_o <= res_val_reg[2:0];
        if (auto_pend_reg) auto_off_reg <= auto_val_reg[0];
        if (ext_pend_reg) ext_in_reg <= ext_val_reg[1:0];
        if (off_pend_reg && !diode_blocked) diode_off_o <= 1'b1;
      end
      res_pend_reg <= 1'b0;
      off_pend_reg <= 1'b0;
      auto_pend_reg <= 1'b0;
      ext_pend_reg <= 1'b0;
      pend_bad_reg <= 1'b0;
    end
  end

  // Status word
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      device_state_word_o <= '0;
    end else begin
      device_state_word_o.spare <= 1'b0;
      case (state_reg)
        ST_BUSY: begin
          device_state_word_o.invalid <= 1'b1;
          device_state_word_o.param_mode <= 1'b1;
          device_state_word_o.pnum <= 4'h0;
          device_state_word_o.value <= 25'h0;
        end
        ST_ECHO: begin
          device_state_word_o.invalid <= 1'b1;
          device_state_word_o.param_mode <= 1'b1;
          device_state_word_o.pnum <= last_pnum_reg;
          device_state_word_o.value <= last_value_reg;
        end
        ST_FAULT: begin
          device_state_word_o.invalid <= 1'b1;
          device_state_word_o.param_mode <= 1'b0;
          device_state_word_o.pnum <= `FAULT_BAD_PARAM;
          device_state_word_o.value <= position_i;
        end
        default: begin
          device_state_word_o.invalid <= 1'b0;
          device_state_word_o.param_mode <= 1'b0;
          device_state_word_o.pnum <= `FAULT_NONE;
          device_state_word_o.value <= position_i;
        end
      endcase
    end
  end

  a_echo_after_busy: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    accept_now |=> ##1 (device_state_word_o.pnum == $past(last_pnum_reg, 2)))
    else $error("echo number mismatch");
  a_fault_code_out: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (enable_now && range_err) |=> ##1 (device_state_word_o.invalid && !device_state_word_o.param_mode
      && device_state_word_o.pnum == `FAULT_BAD_PARAM))
    else $error("malfunction not reported");
  a_no_apply_err: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (enable_now && range_err) |=> $stable(resolution_o))
    else $error("parameter applied despite error");
  a_operate_word: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_reg == ST_OPERATE) ##1 (state_reg == ST_OPERATE) |->
      (!device_state_word_o.invalid && device_state_word_o.pnum == 4'h0))
    else $error("operation word wrong");
  a_busy_state_word: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (state_reg == ST_BUSY) |=> (device_state_word_o.invalid && device_state_word_o.param_mode))
    else $error("busy state bits wrong");
  a_enable_clears_state: assert property (@(posedge sys_clk_i) disable iff (!rstn_i)
    (enable_now && !range_err) |=> ##1 (!device_state_word_o.invalid && !device_state_word_o.param_mode
      && device_state_word_o.pnum == `FAULT_NONE))
    else $error("operation not resumed");

endmodule

/* verif/fieldbus_host_model.sv */
module fieldbus_host_model
  import param_handshake_pkg::*;
(
  input wire logic sys_clk_i,
  input wire stat_word_type stat_i,
  output cmd_word_type cmd_o,
  output logic timeout_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cmd_o = '0;
    timeout_o = 1'b0;
  end
  task automatic put_param(input logic [3:0] pnum, input logic [24:0] val);
    int n;
    @(posedge sys_clk_i);
    cmd_o <= {1'b0, 2'h0, pnum, val};
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (!(stat_i[31:30] === 2'h3 && stat_i.pnum === pnum && stat_i.value === val) && n < 60);
    if (n >= 60) timeout_o = 1'b1;
  endtask
  // Enable held until the state bits change
  task automatic enable_op();
    int n;
    logic [1:0] start;
    @(posedge sys_clk_i);
    start = stat_i[31:30];
    cmd_o <= {1'b1, 2'h0, 4'h0, 25'h0};
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (stat_i[31:30] === start && n < 60);
    if (n >= 60) timeout_o = 1'b1;
    cmd_o <= '0;
  endtask
endmodule

/* verif/parameter_handshake_engine_tb.sv */
module parameter_handshake_engine_tb
  import param_handshake_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic [24:0] position_i = 25'h0;
  cmd_word_type cmd;
  stat_word_type stat;
  logic [2:0] res;
  logic diode_off;
  logic tmo;
  int failures = 0;
  int n_checks = 0;
  int m_res = 1;
  int m_ext = 0;
  int m_auto = 0;
  int m_diode = 0;
  int pend_n[$];
  int pend_v[$];
  always #20 sys_clk_i = ~sys_clk_i;
  parameter_handshake_engine #(.PROC_LEN(4)) dut (.sys_clk_i(sys_clk_i), .rstn_i(rstn_i),
    .host_command_word_i(cmd), .position_i(position_i), .device_state_word_o(stat),
    .resolution_o(res), .diode_off_o(diode_off));
  fieldbus_host_model host (.sys_clk_i(sys_clk_i), .stat_i(stat), .cmd_o(cmd), .timeout_o(tmo));
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic chk_stat(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_apply(input logic [3:0] got, input logic [3:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic stop_on_hang();
    if (tmo !== 1'b0) begin
      failures++;
      report_and_stop();
    end
  endtask
  // Each number at most once per batch, never resent before enable
  task automatic param(input logic [3:0] p, input logic [24:0] v);
    host.put_param(p, v);
    pend_n.push_back(p);
    pend_v.push_back(v);
    stop_on_hang();
  endtask
  task automatic enable_and_check(input string name);
    bit ok;
    int e;
    int a;
    int r;
    logic [31:0] exp_word;
    ok = 1;
    e = m_ext;
    a = m_auto;
    r = m_res;
    foreach (pend_n[i]) begin
      case (pend_n[i])
        1: begin ok &= pend_v[i] <= 5; r = pend_v[i]; end
        5: begin ok &= pend_v[i] <= 1; a = pend_v[i]; end
        12: begin ok &= pend_v[i] <= 3; e = pend_v[i]; end
        default: ;
      endcase
    end
    if (ok) begin
      foreach (pend_n[i]) if (pend_n[i] == 2 && e != 2 && a == 0) m_diode = 1;
      m_res = r;
      m_ext = e;
      m_auto = a;
    end
    pend_n.delete();
    pend_v.delete();
    host.enable_op();
    stop_on_hang();
    exp_word = ok ? {7'h0, position_i} : {7'h41, position_i};
    chk_stat(stat, exp_word);
    chk_apply({diode_off, res}, {m_diode[0], m_res[2:0]});
    @(posedge sys_clk_i);
    chk_stat(stat, exp_word);
    $display("test %s done", name);
  endtask
  initial begin
    logic [3:0] dp[7];
    int dv[7];
    dp = '{4'hc, 4'h2, 4'hc, 4'h5, 4'h2, 4'h5, 4'h2};
    dv = '{2, 0, 0, 1, 0, 0, 0};
    void'($urandom(32'hcb49e01f));
    repeat (6) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    position_i <= 25'($urandom);
    repeat (3) @(posedge sys_clk_i);
    chk_stat(stat, {7'h0, position_i});
    chk_apply({diode_off, res}, 4'h1);
    $display("test reset done");
    for (int v = 0; v < 6; v++) begin
      param(4'h1, 25'(v));
      enable_and_check("resolution");
    end
    param(4'h7, 25'($urandom));
    enable_and_check("unknown number");
    position_i <= 25'($urandom);
    param(4'h1, 25'h6);
    param(4'h8, 25'h1);
    enable_and_check("range error");
    param(4'h1, 25'h1ffffff);
    enable_and_check("minus one");
    enable_and_check("recover");
    for (int i = 0; i < 7; i++) begin
      param(dp[i], 25'(dv[i]));
      enable_and_check("diode");
    end
    report_and_stop();
  end
endmodule
